//--- inc/pes_pkg.sv
// Constants, register map and carrier types of the event select and count block.
// Assumes a single 25 MHz core clock shared by the pipeline and the register bus.
package pes_pkg;

	// ==========================================================================
	// Counter bank
	localparam int          PES_NUM_CTR    = 4;       // Counters numbered 4 to 7
	localparam int          PES_WIDE_CTRS  = 2;       // Counters 4 and 5 take syllable events
	localparam int          PES_MEM_SLOTS  = 2;       // Memory retire ports
	localparam int          PES_SYL_SLOTS  = 6;       // Retired syllables per cycle

	// ==========================================================================
	// Register map, byte addresses
	localparam logic [5:0]  PES_OFF_CFG_BASE  = 6'h00; // monitor_config_reg 4..7
	localparam logic [5:0]  PES_OFF_CNT_BASE  = 6'h10; // monitor_count_reg 4..7
	localparam logic [5:0]  PES_OFF_DBR_LO    = 6'h20; // Data breakpoint range, low
	localparam logic [5:0]  PES_OFF_DBR_HI    = 6'h24; // Data breakpoint range, high
	localparam logic [5:0]  PES_OFF_BANK_MASK = 6'h30;
	localparam logic [31:0] PES_CFG_RST       = 32'h0000_00FF; // Unused code, counts nothing
	localparam logic [31:0] PES_CFG_WMASK     = 32'h000F_07FF; // Reserved bits stay zero
	localparam logic [31:0] PES_CNT_RST       = 32'h0000_0000;
	localparam logic [31:0] PES_DBR_RST       = 32'h0000_0000;

	// ==========================================================================
	// Event codes
	localparam logic [7:0]  PES_EV_BE_FLUSH_CYC  = 8'h00;
	localparam logic [7:0]  PES_EV_ALL_FLUSH_CYC = 8'h04;
	localparam logic [7:0]  PES_EV_FREE_BACKEND  = 8'h05;
	localparam logic [7:0]  PES_EV_MEM_STALL     = 8'h07;
	localparam logic [7:0]  PES_EV_NOPS          = 8'h30;
	localparam logic [7:0]  PES_EV_PRED_SQUASH   = 8'h31;
	localparam logic [7:0]  PES_EV_FLUSH         = 8'h33;
	localparam logic [7:0]  PES_EV_RSE_REFS      = 8'h65;
	localparam logic [7:0]  PES_EV_LOADS         = 8'h6C;
	localparam logic [7:0]  PES_EV_STORES        = 8'h6D;
	localparam logic [7:0]  PES_EV_UC_LOADS      = 8'h6E;
	localparam logic [7:0]  PES_EV_UC_STORES     = 8'h6F;
	localparam logic [7:0]  PES_EV_MIS_LOADS     = 8'h70;
	localparam logic [7:0]  PES_EV_MIS_STORES    = 8'h71;
	localparam logic [7:0]  PES_EV_RSE_LOADS     = 8'h72;
	localparam logic [7:0]  PES_EV_L3_WRITES     = 8'h7E;

	// ==========================================================================
	// Unit mask bit positions and named patterns
	localparam int          PES_UM_WB     = 3;        // L3 write: writeback source
	localparam int          PES_UM_DATA   = 2;        // L3 write: data source
	localparam int          PES_UM_MISS   = 1;
	localparam int          PES_UM_HIT    = 0;
	localparam int          PES_UM_BYPASS = 3;        // Flush reasons
	localparam int          PES_UM_XLATE  = 2;
	localparam int          PES_UM_WAY    = 1;
	localparam int          PES_UM_OTHER  = 0;
	localparam logic [3:0]  PES_L3_WB_HIT   = 4'h9;
	localparam logic [3:0]  PES_L3_WB_MISS  = 4'hA;
	localparam logic [3:0]  PES_L3_DATA_ALL = 4'h7;
	localparam logic [3:0]  PES_L3_DATA_HIT = 4'h5;
	localparam logic [3:0]  PES_L3_DATA_MISS = 4'h6;

	// Largest increment per cycle for each event class
	localparam logic [2:0]  PES_MAX_ONE = 3'h1;
	localparam logic [2:0]  PES_MAX_MEM = 3'h2;
	localparam logic [2:0]  PES_MAX_SYL = 3'h6;

	// ==========================================================================
	// Carrier types
	typedef struct packed {
		logic [11:0] rsvd_hi;
		logic [3:0]  umask;     // Bits 19:16
		logic [4:0]  rsvd_lo;
		logic        dar_en;    // Bit 10: data address range qualifier
		logic        opc_en;    // Bit 9: opcode matcher qualifier
		logic        iar_en;    // Bit 8: instruction address range qualifier
		logic [7:0]  code;      // Bits 7:0
	} pes_cfg_s;

	typedef struct packed {
		logic        valid;
		logic        is_load;       // Else store
		logic        pred_off;
		logic        chk_advanced_load_table_hit;  // check_load that hit advanced_load_table
		logic        misaligned;
		logic        uncacheable;   // Uncacheable or write-coalescing
		logic        register_stack_engine;           // register_stack_engine reference
		logic        tag_iar;       // Of the op, or of the op that caused the reference
		logic        tag_opc;
		logic [31:0] addr;
	} pes_mem_s;

	typedef struct packed {
		logic valid;
		logic is_nop;
		logic is_branch;
		logic pred_off;
		logic tag_iar;
		logic tag_opc;
	} pes_syl_s;

	typedef struct packed {
		logic l3_wr_valid;
		logic l3_wr_hit;
		logic l3_wr_from_wb;
		logic mem_stall;
		logic fe_resteer_taken;
		logic be_resteer_brmisp;
		logic be_resteer_advanced_load_table;
		logic be_resteer_excp;
		logic bypass_conflict_flush;
		logic xlate_miss_flush;
		logic way_mispredict_flush;
		logic other_flush;
		logic be_stall;
		logic be_flush;
		logic dbuf_empty;
	} pes_pipe_s;

endpackage

//--- logic/pes_counter.sv
// Event selection and counting for monitor counters 4 to 7, with Avalon-MM registers.
// Assumes the pipeline, cache and memory units drive events on i_mclk.
module pes_counter
	import pes_pkg::*;
(
	input  wire logic                         i_mclk,
	input  wire logic                         i_rst_b,
	input  wire logic [5:0]                   i_avs_address,
	input  wire logic                         i_avs_read,
	input  wire logic                         i_avs_write,
	input  wire logic [31:0]                  i_avs_writedata,
	input  wire logic [3:0]                   i_avs_byteenable,
	output logic      [31:0]                  o_avs_readdata,
	output logic                              o_avs_waitrequest,
	input  wire pes_mem_s [PES_MEM_SLOTS-1:0] i_mem_ret,
	input  wire pes_syl_s [PES_SYL_SLOTS-1:0] i_syl_ret,
	input  wire pes_pipe_s                    i_pipe
);

	// ==========================================================================
	// Bus slave
	logic        ack;
	logic [31:0] dbr_lo;
	logic [31:0] dbr_hi;
	wire         bus_req  = i_avs_read | i_avs_write;
	wire         wr_fire  = i_avs_write & ack;
	wire  [1:0]  sel      = i_avs_address[3:2];
	wire         hit_cfg  = (i_avs_address & PES_OFF_BANK_MASK) == PES_OFF_CFG_BASE;
	wire         hit_cnt  = (i_avs_address & PES_OFF_BANK_MASK) == PES_OFF_CNT_BASE;
	wire         hit_lo   = i_avs_address == PES_OFF_DBR_LO;
	wire         hit_hi   = i_avs_address == PES_OFF_DBR_HI;
	wire  [31:0] cfg_bus [PES_NUM_CTR];
	wire  [31:0] cnt_bus [PES_NUM_CTR];
	wire  [31:0] rd_mux;

	// One wait cycle, then the answer
	assign o_avs_waitrequest = bus_req & ~ack;
	assign rd_mux = hit_cfg ? cfg_bus[sel] :
	                hit_cnt ? cnt_bus[sel] :
	                hit_lo  ? dbr_lo :
	                hit_hi  ? dbr_hi : 32'h0000_0000;

	// Byte-lane merge of a write
	function automatic logic [31:0] be_merge(input logic [31:0] old_v,
	                                         input logic [31:0] new_v,
	                                         input logic [3:0]  be);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// Handshake and read data
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			ack            <= 1'b0;
			o_avs_readdata <= 32'h0000_0000;
		end else begin
			ack <= bus_req & ~ack;
			if (i_avs_read & ~ack) begin
				o_avs_readdata <= rd_mux;
			end
		end
	end

	// Data breakpoint range registers
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			dbr_lo <= PES_DBR_RST;
			dbr_hi <= PES_DBR_RST;
		end else if (wr_fire) begin
			if (hit_lo) begin
				dbr_lo <= be_merge(dbr_lo, i_avs_writedata, i_avs_byteenable);
			end
			if (hit_hi) begin
				dbr_hi <= be_merge(dbr_hi, i_avs_writedata, i_avs_byteenable);
			end
		end
	end

	// ==========================================================================
	// Data address range check per memory port, own address of each reference
	logic [PES_MEM_SLOTS-1:0] dar_hit;
	logic [PES_MEM_SLOTS-1:0] ld_good;
	genvar m;
	generate
		for (m = 0; m < PES_MEM_SLOTS; m++) begin : g_dar
			assign dar_hit[m] = (i_mem_ret[m].addr >= dbr_lo) &&
			                    (i_mem_ret[m].addr <= dbr_hi);
			// Unqualified countable load per port, for the checks below
			assign ld_good[m] = i_mem_ret[m].valid & i_mem_ret[m].is_load &
			                    ~i_mem_ret[m].pred_off & ~i_mem_ret[m].chk_advanced_load_table_hit;
		end
	endgenerate

	// ==========================================================================
	// Event decode: qualifying events this cycle for one counter
	function automatic logic [2:0] calc_inc(input pes_cfg_s c, input logic wide);
		logic [2:0] n;
		logic [2:0] mx;
		logic       q;
		logic       ld;
		logic       st;
		logic       hit;
		logic       l3;
		pes_mem_s   mr;
		pes_syl_s   sy;
		n  = 3'h0;
		mx = PES_MAX_ONE;
		l3 = i_pipe.l3_wr_valid &
		     ((c.umask[PES_UM_WB] & i_pipe.l3_wr_from_wb) |
		      (c.umask[PES_UM_DATA] & ~i_pipe.l3_wr_from_wb)) &
		     ((c.umask[PES_UM_HIT] & i_pipe.l3_wr_hit) |
		      (c.umask[PES_UM_MISS] & ~i_pipe.l3_wr_hit));
		// Memory retire ports
		for (int i = 0; i < PES_MEM_SLOTS; i++) begin
			mr  = i_mem_ret[i];
			q   = mr.valid & ~mr.pred_off &
			      (~c.iar_en | mr.tag_iar) & (~c.opc_en | mr.tag_opc) &
			      (~c.dar_en | dar_hit[i]);
			ld  = q & mr.is_load & ~mr.chk_advanced_load_table_hit;
			st  = q & ~mr.is_load;
			case (c.code)
				PES_EV_LOADS:      hit = ld;
				PES_EV_MIS_LOADS:  hit = ld & mr.misaligned;
				PES_EV_MIS_STORES: hit = st & mr.misaligned;
				PES_EV_STORES:     hit = st;
				PES_EV_UC_LOADS:   hit = ld & mr.uncacheable;
				PES_EV_UC_STORES:  hit = st & mr.uncacheable;
				PES_EV_RSE_LOADS:  hit = ld & mr.register_stack_engine;
				PES_EV_RSE_REFS:   hit = (ld | st) & mr.register_stack_engine;
				default:           hit = 1'b0;
			endcase
			n = n + {2'b00, hit};
		end
		// Retired syllables, counters 4 and 5 only
		for (int i = 0; i < PES_SYL_SLOTS; i++) begin
			sy = i_syl_ret[i];
			q  = wide & sy.valid &
			     (~c.iar_en | sy.tag_iar) & (~c.opc_en | sy.tag_opc);
			case (c.code)
				PES_EV_NOPS:        hit = q & sy.is_nop & ~sy.pred_off;
				PES_EV_PRED_SQUASH: hit = q & sy.pred_off & ~sy.is_branch;
				default:            hit = 1'b0;
			endcase
			n = n + {2'b00, hit};
		end
		// Single-bit cycle and occurrence events
		case (c.code)
			PES_EV_L3_WRITES: n = {2'b00, l3};
			PES_EV_MEM_STALL: n = {2'b00, i_pipe.mem_stall};
			PES_EV_ALL_FLUSH_CYC: begin
				n = {2'b00, i_pipe.fe_resteer_taken | i_pipe.be_resteer_brmisp |
				     i_pipe.be_resteer_advanced_load_table | i_pipe.be_resteer_excp};
			end
			PES_EV_BE_FLUSH_CYC: begin
				n = {2'b00, i_pipe.be_resteer_brmisp | i_pipe.be_resteer_advanced_load_table |
				     i_pipe.be_resteer_excp};
			end
			PES_EV_FLUSH: begin
				n = {2'b00,
				     (c.umask[PES_UM_BYPASS] & i_pipe.bypass_conflict_flush) |
				     (c.umask[PES_UM_XLATE]  & i_pipe.xlate_miss_flush) |
				     (c.umask[PES_UM_WAY]    & i_pipe.way_mispredict_flush) |
				     (c.umask[PES_UM_OTHER]  & i_pipe.other_flush)};
			end
			PES_EV_FREE_BACKEND: begin
				n = {2'b00, ~i_pipe.be_stall & ~i_pipe.be_flush & i_pipe.dbuf_empty};
			end
			default: n = n;
		endcase
		// Per-class ceiling
		case (c.code)
			PES_EV_LOADS, PES_EV_STORES, PES_EV_UC_LOADS, PES_EV_UC_STORES,
			PES_EV_MIS_LOADS, PES_EV_MIS_STORES, PES_EV_RSE_LOADS,
			PES_EV_RSE_REFS:                  mx = PES_MAX_MEM;
			PES_EV_NOPS, PES_EV_PRED_SQUASH:  mx = PES_MAX_SYL;
			default:                          mx = PES_MAX_ONE;
		endcase
		return (n > mx) ? mx : n;
	endfunction

	// ==========================================================================
	// Counter bank: config and count register per counter
	genvar g;
	generate
		for (g = 0; g < PES_NUM_CTR; g++) begin : g_ctr
			pes_cfg_s    cfg;
			logic [31:0] cnt;
			logic [2:0]  inc;
			wire         cfg_wr = wr_fire & hit_cfg & (sel == 2'(g));
			wire         cnt_wr = wr_fire & hit_cnt & (sel == 2'(g));

			// A process, not an assign: it must wake on the ports read in the function
			always_comb inc = calc_inc(cfg, g < PES_WIDE_CTRS);
			assign cfg_bus[g] = cfg;
			assign cnt_bus[g] = cnt;

			// Config register, reserved bits forced low
			always_ff @(posedge i_mclk) begin
				if (!i_rst_b) begin
					cfg <= PES_CFG_RST;
				end else if (cfg_wr) begin
					cfg <= be_merge(cfg, i_avs_writedata, i_avs_byteenable) & PES_CFG_WMASK;
				end
			end

			// Count register, software write wins over counting
			always_ff @(posedge i_mclk) begin
				if (!i_rst_b) begin
					cnt <= PES_CNT_RST;
				end else if (cnt_wr) begin
					cnt <= be_merge(cnt, i_avs_writedata, i_avs_byteenable);
				end else begin
					cnt <= cnt + {29'h0, inc};
				end
			end
		end
	endgenerate

	// ==========================================================================
	// Assertions on counter 4 (and 6 for the restricted events)
	pes_cfg_s    c0;
	pes_cfg_s    c2;
	logic [31:0] cnt0;
	logic [31:0] cnt2;
	logic        quiet0;
	logic        quiet2;
	logic        plain0;
	assign c0     = cfg_bus[0];
	assign c2     = cfg_bus[2];
	assign cnt0   = cnt_bus[0];
	assign cnt2   = cnt_bus[2];
	assign quiet0 = ~(wr_fire & hit_cnt & (sel == 2'h0));
	assign quiet2 = ~(wr_fire & hit_cnt & (sel == 2'h2));
	assign plain0 = ~c0.iar_en & ~c0.opc_en & ~c0.dar_en;

	property p_l3_wb_hit;
		@(posedge i_mclk) disable iff (!i_rst_b)
		(c0.code == PES_EV_L3_WRITES && c0.umask == PES_L3_WB_HIT && quiet0 &&
		 i_pipe.l3_wr_valid && i_pipe.l3_wr_hit && i_pipe.l3_wr_from_wb)
		|=> (cnt0 == $past(cnt0) + 32'h1);
	endproperty
	a_l3_wb_hit: assert property (p_l3_wb_hit) else $error("wb hit not counted");

	property p_l3_wb_miss;
		@(posedge i_mclk) disable iff (!i_rst_b)
		(c0.code == PES_EV_L3_WRITES && c0.umask == PES_L3_WB_MISS && quiet0 &&
		 i_pipe.l3_wr_valid && i_pipe.l3_wr_hit)
		|=> (cnt0 == $past(cnt0));
	endproperty
	a_l3_wb_miss: assert property (p_l3_wb_miss) else $error("hit counted as miss");

	property p_l3_data_all;
		@(posedge i_mclk) disable iff (!i_rst_b)
		(c0.code == PES_EV_L3_WRITES && c0.umask == PES_L3_DATA_ALL && quiet0 &&
		 i_pipe.l3_wr_valid && !i_pipe.l3_wr_from_wb)
		|=> (cnt0 == $past(cnt0) + 32'h1);
	endproperty
	a_l3_data_all: assert property (p_l3_data_all) else $error("data write missed");

	property p_loads_two;
		@(posedge i_mclk) disable iff (!i_rst_b)
		(c0.code == PES_EV_LOADS && plain0 && quiet0)
		|=> (cnt0 == $past(cnt0) + {31'h0, $past(ld_good[0])} +
		             {31'h0, $past(ld_good[1])});
	endproperty
	a_loads_two: assert property (p_loads_two) else $error("dual load not counted");

	property p_advanced_load_table_excl;
		@(posedge i_mclk) disable iff (!i_rst_b)
		(c0.code == PES_EV_LOADS && quiet0 && !i_mem_ret[1].valid &&
		 i_mem_ret[0].chk_advanced_load_table_hit)
		|=> (cnt0 == $past(cnt0));
	endproperty
	a_advanced_load_table_excl: assert property (p_advanced_load_table_excl) else $error("table hit counted");

	property p_mem_stall;
		@(posedge i_mclk) disable iff (!i_rst_b)
		(c0.code == PES_EV_MEM_STALL && quiet0)
		|=> (cnt0 == $past(cnt0) + {31'h0, $past(i_pipe.mem_stall)});
	endproperty
	a_mem_stall: assert property (p_mem_stall) else $error("stall cycle count wrong");

	property p_nop_narrow;
		@(posedge i_mclk) disable iff (!i_rst_b)
		(c2.code == PES_EV_NOPS && quiet2) |=> (cnt2 == $past(cnt2));
	endproperty
	a_nop_narrow: assert property (p_nop_narrow) else $error("nop on counter 6");

	property p_flush_union;
		@(posedge i_mclk) disable iff (!i_rst_b)
		(c0.code == PES_EV_FLUSH && c0.umask == 4'hC && quiet0 &&
		 (i_pipe.bypass_conflict_flush || i_pipe.xlate_miss_flush))
		|=> (cnt0 == $past(cnt0) + 32'h1);
	endproperty
	a_flush_union: assert property (p_flush_union) else $error("flush union wrong");

	property p_free_be;
		@(posedge i_mclk) disable iff (!i_rst_b)
		(c0.code == PES_EV_FREE_BACKEND && quiet0 && i_pipe.be_stall)
		|=> (cnt0 == $past(cnt0));
	endproperty
	a_free_be: assert property (p_free_be) else $error("stalled cycle counted");

	property p_dar_own;
		@(posedge i_mclk) disable iff (!i_rst_b)
		(c0.code == PES_EV_RSE_REFS && c0.dar_en && quiet0 && !i_mem_ret[1].valid &&
		 !dar_hit[0])
		|=> (cnt0 == $past(cnt0));
	endproperty
	a_dar_own: assert property (p_dar_own) else $error("out-of-range ref counted");

	property p_be_flush;
		@(posedge i_mclk) disable iff (!i_rst_b)
		(c0.code == PES_EV_BE_FLUSH_CYC && quiet0 && !i_pipe.be_resteer_brmisp &&
		 !i_pipe.be_resteer_advanced_load_table && !i_pipe.be_resteer_excp)
		|=> (cnt0 == $past(cnt0));
	endproperty
	a_be_flush: assert property (p_be_flush) else $error("wrong back-end cycle");

	property p_all_flush;
		@(posedge i_mclk) disable iff (!i_rst_b)
		(c0.code == PES_EV_ALL_FLUSH_CYC && quiet0 && i_pipe.fe_resteer_taken)
		|=> (cnt0 == $past(cnt0) + 32'h1);
	endproperty
	a_all_flush: assert property (p_all_flush) else $error("taken resteer missed");

	property p_store_excl;
		@(posedge i_mclk) disable iff (!i_rst_b)
		(c0.code == PES_EV_STORES && quiet0 &&
		 (!i_mem_ret[0].valid || i_mem_ret[0].is_load || i_mem_ret[0].pred_off) &&
		 (!i_mem_ret[1].valid || i_mem_ret[1].is_load || i_mem_ret[1].pred_off))
		|=> (cnt0 == $past(cnt0));
	endproperty
	a_store_excl: assert property (p_store_excl) else $error("non-store counted");

	property p_bus_answer;
		@(posedge i_mclk) disable iff (!i_rst_b)
		(bus_req && o_avs_waitrequest) |=> !o_avs_waitrequest;
	endproperty
	a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

	c_two_loads: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
		cnt0 == $past(cnt0) + 32'h2);
	c_flush: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
		c0.code == PES_EV_FLUSH && i_pipe.other_flush);
	c_cnt_write: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
		wr_fire && hit_cnt);

endmodule // pes_counter

//--- test/pes_event_src.sv
// Random event source standing in for the pipeline, cache and memory units.
// Assumes the bench gives i_run; outputs change just after each rising edge.
module pes_event_src
	import pes_pkg::*;
(
	input  wire logic                     i_mclk,
	input  wire logic                     i_run,
	output pes_mem_s  [PES_MEM_SLOTS-1:0] o_mem,
	output pes_syl_s  [PES_SYL_SLOTS-1:0] o_syl,
	output pes_pipe_s                     o_pipe
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [63:0] r;

	// ==========================================================================
	// Fresh events each cycle while running, none otherwise
	always @(posedge i_mclk) begin
		for (int k = 0; k < PES_MEM_SLOTS; k++) begin
			r = {$urandom, $urandom};
			r[31:8] = '0;            // Addresses near the breakpoint range
			r[37] = r[37] & r[39];   // Table hit only on a check load
			o_mem[k] <= i_run ? pes_mem_s'(r[40:0]) : '0;
		end
		for (int k = 0; k < PES_SYL_SLOTS; k++) begin
			r = {32'h0, $urandom};
			o_syl[k] <= i_run ? pes_syl_s'(r[5:0]) : '0;
		end
		r = {32'h0, $urandom};
		o_pipe <= i_run ? pes_pipe_s'(r[14:0]) : '0;
	end
endmodule // pes_event_src

//--- test/tb_pes_counter.sv
// Self-checking bench of the event select and count block.
// Assumes pes_counter and pes_event_src; one 25 MHz clock, Avalon-MM master here.
module tb_pes_counter;
	import pes_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	logic                     mclk = 1'b0;
	logic                     rst_b = 1'b0;
	logic [5:0]               avs_address = 6'h00;
	logic                     avs_read = 1'b0;
	logic                     avs_write = 1'b0;
	logic [31:0]              avs_writedata = 32'h0;
	logic [31:0]              avs_readdata;
	logic                     avs_waitrequest;
	logic                     run = 1'b0;
	pes_mem_s [PES_MEM_SLOTS-1:0] mem;
	pes_syl_s [PES_SYL_SLOTS-1:0] syl;
	pes_pipe_s                pipe;
	pes_cfg_s                 cur_cfg = '0;
	int                       cur_ctr = 0;
	logic [31:0]              acc = 32'h0;
	logic [31:0]              rng_lo = 32'h0;
	logic [31:0]              rng_hi = 32'h0;
	int                       bad_count = 0;
	int                       n_checks = 0;
	int                       cyc = 0;
	logic [11:0]              tbl [25] = '{
		12'h7E9, 12'h7EA, 12'h7E7, 12'h7E5, 12'h7E6,
		12'h6C0, 12'h070, 12'h700, 12'h710, 12'h300,
		12'h040, 12'h000, 12'h33F, 12'h338, 12'h334,
		12'h332, 12'h331, 12'h310, 12'h720, 12'h650,
		12'h6D0, 12'h6E0, 12'h6F0, 12'h050, 12'h33C};

	// ==========================================================================
	// Design and event source
	pes_counter i_pes_counter (
		.i_mclk            (mclk),
		.i_rst_b           (rst_b),
		.i_avs_address     (avs_address),
		.i_avs_read        (avs_read),
		.i_avs_write       (avs_write),
		.i_avs_writedata   (avs_writedata),
		.i_avs_byteenable  (4'hF),
		.o_avs_readdata    (avs_readdata),
		.o_avs_waitrequest (avs_waitrequest),
		.i_mem_ret         (mem),
		.i_syl_ret         (syl),
		.i_pipe            (pipe)
	);
	pes_event_src i_pes_event_src (
		.i_mclk (mclk),
		.i_run  (run),
		.o_mem  (mem),
		.o_syl  (syl),
		.o_pipe (pipe)
	);

	// ==========================================================================
	// Clock, expected running sum, hang guard
	initial begin
		forever #20 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		cyc++;
		if (rst_b)
			acc <= acc + ev_count(cur_cfg, cur_ctr);
		if (cyc == 12000) begin
			bad_count++;
			summarize();
		end
	end

	// ==========================================================================
	// Expected events of one cycle
	function automatic logic [31:0] ev_count(pes_cfg_s c, int ctr);
		logic [31:0] n;
		logic        q;
		n = 32'h0;
		for (int k = 0; k < PES_MEM_SLOTS; k++) begin
			q = mem[k].valid && !mem[k].pred_off && (!c.iar_en || mem[k].tag_iar)
				&& (!c.opc_en || mem[k].tag_opc) && !(mem[k].is_load && mem[k].chk_advanced_load_table_hit)
				&& (!c.dar_en || (mem[k].addr >= rng_lo && mem[k].addr <= rng_hi));
			case (c.code)
				8'h6C: n += 32'(q && mem[k].is_load);
				8'h6D: n += 32'(q && !mem[k].is_load);
				8'h6E: n += 32'(q && mem[k].is_load && mem[k].uncacheable);
				8'h6F: n += 32'(q && !mem[k].is_load && mem[k].uncacheable);
				8'h70: n += 32'(q && mem[k].is_load && mem[k].misaligned);
				8'h71: n += 32'(q && !mem[k].is_load && mem[k].misaligned);
				8'h72: n += 32'(q && mem[k].is_load && mem[k].register_stack_engine);
				8'h65: n += 32'(q && mem[k].register_stack_engine);
				default: ;
			endcase
		end
		for (int k = 0; k < PES_SYL_SLOTS; k++) begin
			q = syl[k].valid && (!c.iar_en || syl[k].tag_iar) && (!c.opc_en || syl[k].tag_opc)
				&& ctr < 2;
			if (c.code == 8'h30)
				n += 32'(q && syl[k].is_nop && !syl[k].pred_off);
			if (c.code == 8'h31)
				n += 32'(q && syl[k].pred_off && !syl[k].is_branch);
		end
		q = pipe.be_resteer_brmisp || pipe.be_resteer_advanced_load_table || pipe.be_resteer_excp;
		case (c.code)
			8'h00: n += 32'(q);
			8'h04: n += 32'(q || pipe.fe_resteer_taken);
			8'h05: n += 32'(!pipe.be_stall && !pipe.be_flush && pipe.dbuf_empty);
			8'h07: n += 32'(pipe.mem_stall);
			8'h33: n += 32'(|(c.umask & {pipe.bypass_conflict_flush, pipe.xlate_miss_flush,
				pipe.way_mispredict_flush, pipe.other_flush}));
			8'h7E: n += 32'(pipe.l3_wr_valid
				&& ((c.umask[3] && pipe.l3_wr_from_wb) || (c.umask[2] && !pipe.l3_wr_from_wb))
				&& ((c.umask[1] && !pipe.l3_wr_hit) || (c.umask[0] && pipe.l3_wr_hit)));
			default: ;
		endcase
		return n;
	endfunction

	// ==========================================================================
	// Bus access, compare, verdict
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge mclk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= wd;
		do begin
			@(posedge mclk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		n_checks++;
		if (got !== want) begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, want);
		end
	endtask

	task automatic summarize();
		if (bad_count == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ==========================================================================
	// Main sequence
	initial begin
		logic [31:0] d;
		logic [31:0] base;
		pes_cfg_s    c;
		void'($urandom(32'hB1A2));
		repeat (5) @(posedge mclk);
		rst_b <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			bus(1'b0, PES_OFF_CFG_BASE + 6'(4 * i), 32'h0, d);
			chk(d, PES_CFG_RST);
			bus(1'b0, PES_OFF_CNT_BASE + 6'(4 * i), 32'h0, d);
			chk(d, PES_CNT_RST);
		end
		bus(1'b1, PES_OFF_CFG_BASE, 32'hFFFF_FFFF, d);
		bus(1'b0, PES_OFF_CFG_BASE, 32'h0, d);
		chk(d, PES_CFG_WMASK);
		bus(1'b1, 6'h3C, 32'hFFFF_FFFF, d);
		bus(1'b0, 6'h3C, 32'h0, d);
		chk(d, 32'h0);
		rng_lo = 32'h0000_0040;
		rng_hi = 32'h0000_00BF;
		bus(1'b1, PES_OFF_DBR_LO, rng_lo, d);
		bus(1'b1, PES_OFF_DBR_HI, rng_hi, d);
		bus(1'b0, PES_OFF_DBR_HI, 32'h0, d);
		chk(d, rng_hi);
		for (int p = 0; p < 4; p++) begin
			for (int i = 0; i < 25; i++) begin
				c = '0;
				{c.code, c.umask} = tbl[i];
				if (p == 1 && c.code inside {[8'h30:8'h31], [8'h65:8'h72]})
					{c.dar_en, c.opc_en, c.iar_en} = 3'($urandom) | 3'h4;
				cur_ctr = (i + p) % 4;
				cur_cfg = c;
				bus(1'b1, PES_OFF_CFG_BASE + 6'(4 * cur_ctr), c, d);
				bus(1'b1, PES_OFF_CNT_BASE + 6'(4 * cur_ctr), 32'h0, d);
				base = acc;
				run <= 1'b1;
				repeat (40) @(posedge mclk);
				run <= 1'b0;
				repeat (3) @(posedge mclk);
				bus(1'b0, PES_OFF_CNT_BASE + 6'(4 * cur_ctr), 32'h0, d);
				chk(d, acc - base);
			end
		end
		summarize();
	end
endmodule // tb_pes_counter
